// ---- inc/ffa_pkg.sv ----
// shared constants, types and state codes for the flash fetch accelerator
package ffa_pkg;
    // ****************************************************************
    // widths and field positions
    // ****************************************************************
    localparam int ADDR_W = 32;
    localparam int LINE_W = 128;
    localparam int WORD_W = 32;
    localparam int TAG_W = 15;
    localparam int TAG_LSB = 4;
    localparam int WSEL_LSB = 2;
    localparam int WSEL_W = 2;
    localparam int TIM_W = 3;
    localparam int KIND_W = 2;
    localparam int KIND_DATA_BIT = 0;

    // ****************************************************************
    // mode and timing encodings
    // ****************************************************************
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_PART = 2'h1;
    localparam logic [1:0] MODE_FULL = 2'h2;
    localparam logic [1:0] MODE_RSVD = 2'h3;
    localparam logic [2:0] TIM_RSVD = 3'h0;
    localparam logic [2:0] TIM_BYPASS = 3'h1;
    localparam logic [2:0] TIM_RESET = 3'h7;

    // ****************************************************************
    // flash engine access kinds
    // ****************************************************************
    localparam logic [1:0] ENG_NONE = 2'h0;
    localparam logic [1:0] ENG_PREF = 2'h1;
    localparam logic [1:0] ENG_INSTR = 2'h2;
    localparam logic [1:0] ENG_DATA = 2'h3;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_FETCH = 4'h2,
        ST_PFWAIT = 4'h4,
        ST_MIMIC = 4'h8
    } ffa_state_t;

    typedef struct packed {
        logic valid;
        logic seq;
        logic [KIND_W-1:0] kind;
        logic [ADDR_W-1:0] addr;
    } ffa_core_req_t;

    typedef struct packed {
        logic wr;
        logic [1:0] mode;
        logic [TIM_W-1:0] timing;
    } ffa_cfg_t;

    typedef struct packed {
        logic rdEn;
        logic [TAG_W-1:0] line;
    } ffa_flash_req_t;
endpackage

// ---- rtl/ffa_line_buf.sv ----
// one line buffer with its line address latch, comparator and word muxes
`timescale 1ns/1ps
module ffa_line_buf #(
    parameter int LINE_W = ffa_pkg::LINE_W,
    parameter int WORD_W = ffa_pkg::WORD_W,
    parameter int TAG_W = ffa_pkg::TAG_W,
    parameter int WSEL_W = ffa_pkg::WSEL_W
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic invalidate,
    input wire logic load,
    input wire logic [TAG_W-1:0] loadTag,
    input wire logic [LINE_W-1:0] loadLine,
    input wire logic [TAG_W-1:0] lookupTag,
    input wire logic [WSEL_W-1:0] wordSel,
    output logic hit,
    output logic [WORD_W-1:0] word
);
    logic valid_q;
    logic [TAG_W-1:0] tag_q;
    logic [LINE_W-1:0] line_q;

    // valid flag: invalidation beats a load in the same cycle so no stale line survives
    always_ff @(posedge core_clk) begin
        if (rst || invalidate) begin
            valid_q <= 1'b0;
        end else if (load) begin
            valid_q <= 1'b1;
        end
    end

    // line and line address latches
    always_ff @(posedge core_clk) begin
        if (load) begin
            tag_q <= loadTag;
            line_q <= loadLine;
        end
    end

    // comparator
    assign hit = valid_q && (tag_q == lookupTag);

    // one 4:1 multiplexer per bit of the word
    genvar b;
    generate
        for (b = 0; b < WORD_W; b++) begin : g_mux
            wire [3:0] column = {line_q[3*WORD_W+b], line_q[2*WORD_W+b],
                                 line_q[WORD_W+b], line_q[b]};
            assign word[b] = column[wordSel];
        end
    endgenerate
endmodule

// ---- rtl/ffa_fetch_timer.sv ----
// programmable flash access length timer, gives a done pulse after len cycles
`timescale 1ns/1ps
module ffa_fetch_timer #(
    parameter int TIM_W = ffa_pkg::TIM_W
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic start,
    input wire logic abort,
    input wire logic [TIM_W-1:0] len,
    output logic busy,
    output logic done
);
    localparam logic [TIM_W-1:0] CNT_LAST = TIM_W'(1);
    logic busy_q;
    logic [TIM_W-1:0] cnt_q;

    assign busy = busy_q;
    assign done = busy_q && (cnt_q == CNT_LAST);

    // a start restarts the count even while busy
    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy_q <= 1'b0;
            cnt_q <= '0;
        end else if (start) begin
            busy_q <= 1'b1;
            cnt_q <= len;
        end else if (abort || done) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            cnt_q <= cnt_q - CNT_LAST;
        end
    end
endmodule

// ---- rtl/ffa_flash_accel.sv ----
// flash fetch accelerator top: line buffers, prefetch engine, wait logic
//
// Overview of operation
// - three 128-bit buffers: prefetch, branch, data
// - instruction miss stalls core, reads whole line
// - miss on running prefetch waits for it
// - next prefetch starts when flash goes idle
// - held prefetch moves in on match, dropped on a code miss
// - prefetch address is latched address plus one
// - access-kind bit zero splits code from data
// - data line crossing reads flash, aborts prefetch
// - aborted prefetch restarts after data read
// - branch target captured in branch trail buffer
// - four words, 15-bit tag, word muxes
// - data miss fills data buffer with line
// - flash busy programming drops core wait gate while a core request is valid
// - program start invalidates all buffers
// - mode 0 always flash timing, no prefetch
// - mode 1 serves sequential code hits only
// - mode 2 serves every buffer hit
// - buffered data keeps flash read timing in modes 0 and 1
// - timing of one clock means no delay
// - resets disabled, mode may change anytime
// - mode codes 00 off, 01 part, 10 full
// - timing 1 to 7 clocks, resets to 7
// - mode change invalidates all buffers
`timescale 1ns/1ps
module ffa_flash_accel #(
    parameter int LINE_W = ffa_pkg::LINE_W,
    parameter int WORD_W = ffa_pkg::WORD_W,
    parameter int TAG_W = ffa_pkg::TAG_W
) (
    input wire logic core_clk,
    input wire logic rst,
    input ffa_pkg::ffa_core_req_t coreReq,
    input ffa_pkg::ffa_cfg_t cfgIn,
    input wire logic flashProgBusy,
    input wire logic flashProgStart,
    input wire logic [LINE_W-1:0] flashLineData,
    output ffa_pkg::ffa_flash_req_t flashReq,
    output logic coreWaitGate,
    output logic coreReady,
    output logic [WORD_W-1:0] coreRdData,
    output logic [1:0] modeOut,
    output logic [ffa_pkg::TIM_W-1:0] timingOut
);
    // ****************************************************************
    // declarations
    // ****************************************************************
    ffa_pkg::ffa_state_t state_q, state_d;
    logic [1:0] cfgMode_q;
    logic [ffa_pkg::TIM_W-1:0] cfgTim_q;
    ffa_pkg::ffa_flash_req_t flashReq_q;
    logic coreWaitGate_q, coreReady_q;
    logic [WORD_W-1:0] coreRdData_q, mimicWord_q;
    logic [1:0] engKind_q;
    logic [TAG_W-1:0] engLine_q, pfNext_q, pfHeldLine_q;
    logic engSeq_q, pfWanted_q, pfHeldValid_q;
    logic [LINE_W-1:0] pfHeldData_q;

    // word select out of a whole line
    function automatic logic [WORD_W-1:0] pickWord(input logic [LINE_W-1:0] line,
                                                   input logic [ffa_pkg::WSEL_W-1:0] sel);
        pickWord = line[sel*WORD_W +: WORD_W];
    endfunction

    // ****************************************************************
    // configuration
    // ****************************************************************
    wire modeWrOk = cfgIn.wr && (cfgIn.mode != ffa_pkg::MODE_RSVD);
    wire timWrOk = cfgIn.wr && (cfgIn.timing != ffa_pkg::TIM_RSVD);
    wire modeChange = modeWrOk && (cfgIn.mode != cfgMode_q);
    wire invalidate = flashProgStart || modeChange;
    wire pfEnabled = (cfgMode_q == ffa_pkg::MODE_PART) || (cfgMode_q == ffa_pkg::MODE_FULL);
    wire modeFull = (cfgMode_q == ffa_pkg::MODE_FULL);
    wire modePart = (cfgMode_q == ffa_pkg::MODE_PART);

    // mode and timing holders, accepted at any time
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfgMode_q <= ffa_pkg::MODE_OFF;
            cfgTim_q <= ffa_pkg::TIM_RESET;
        end else begin
            if (modeWrOk) begin
                cfgMode_q <= cfgIn.mode;
            end
            if (timWrOk) begin
                cfgTim_q <= cfgIn.timing;
            end
        end
    end

    // ****************************************************************
    // request decode and buffer lookup
    // ****************************************************************
    wire engBusy, engDone, mimicDone;
    wire pfHit, btHit, dHit;
    wire [WORD_W-1:0] pfWord, btWord, dWord;
    wire isInstr = !coreReq.kind[ffa_pkg::KIND_DATA_BIT];
    wire [TAG_W-1:0] reqLine = coreReq.addr[ffa_pkg::TAG_LSB +: TAG_W];
    wire [ffa_pkg::WSEL_W-1:0] wsel = coreReq.addr[ffa_pkg::WSEL_LSB +: ffa_pkg::WSEL_W];
    wire take = (state_q == ffa_pkg::ST_IDLE) && coreReq.valid && !coreReady_q
                && !flashProgBusy && !invalidate && !engDone;
    wire instrHit = pfHit || btHit;
    wire bufHit = isInstr ? instrHit : dHit;
    wire [WORD_W-1:0] bufWord = !isInstr ? dWord : (pfHit ? pfWord : btWord);
    // which hits the mode lets through at once
    wire serveFast = bufHit && (modeFull || (modePart && isInstr && coreReq.seq));
    wire mimicGo = bufHit && !serveFast;
    wire heldMatch = pfEnabled && isInstr && pfHeldValid_q && (pfHeldLine_q == reqLine);
    wire flightMatch = pfEnabled && isInstr && engBusy && (engKind_q == ffa_pkg::ENG_PREF)
                       && (engLine_q == reqLine);
    wire goFetch = take && !bufHit && !heldMatch && !flightMatch;
    wire bypass = (cfgTim_q == ffa_pkg::TIM_BYPASS);

    // ****************************************************************
    // flash engine
    // ****************************************************************
    wire demandStart = goFetch;
    wire [1:0] demandKind = isInstr ? ffa_pkg::ENG_INSTR : ffa_pkg::ENG_DATA;
    wire pfInFlight = engBusy && (engKind_q == ffa_pkg::ENG_PREF);
    wire pfAbortByDemand = demandStart && pfInFlight;
    wire pfLaunch = !engBusy && !flashProgBusy && pfEnabled && pfWanted_q && !pfHeldValid_q
                    && !demandStart && !invalidate;
    wire engStart = demandStart || pfLaunch;
    wire engAbort = invalidate && pfInFlight;
    wire prefDone = engDone && (engKind_q == ffa_pkg::ENG_PREF);
    wire demandDone = engDone && (state_q == ffa_pkg::ST_FETCH)
                      && (engKind_q != ffa_pkg::ENG_PREF);

    ffa_fetch_timer #(.TIM_W(ffa_pkg::TIM_W)) u_flash_timer (
        .core_clk(core_clk),
        .rst(rst),
        .start(engStart),
        .abort(engAbort),
        .len(cfgTim_q),
        .busy(engBusy),
        .done(engDone)
    );

    // engine bookkeeping and flash read request
    always_ff @(posedge core_clk) begin
        if (rst) begin
            engKind_q <= ffa_pkg::ENG_NONE;
            engLine_q <= '0;
            engSeq_q <= 1'b0;
            flashReq_q <= '0;
        end else if (engStart) begin
            engKind_q <= demandStart ? demandKind : ffa_pkg::ENG_PREF;
            engLine_q <= demandStart ? reqLine : pfNext_q;
            engSeq_q <= coreReq.seq;
            flashReq_q.rdEn <= 1'b1;
            flashReq_q.line <= demandStart ? reqLine : pfNext_q;
        end else if (engDone || engAbort) begin
            engKind_q <= ffa_pkg::ENG_NONE;
            flashReq_q.rdEn <= 1'b0;
        end
    end

    // ****************************************************************
    // buffer loads
    // ****************************************************************
    wire pfMoveHeld = take && heldMatch;
    wire pfMoveFlight = (state_q == ffa_pkg::ST_PFWAIT) && prefDone;
    wire pfLoad = (demandDone && (engKind_q == ffa_pkg::ENG_INSTR) && engSeq_q)
                  || pfMoveHeld || pfMoveFlight;
    wire btLoad = demandDone && (engKind_q == ffa_pkg::ENG_INSTR) && !engSeq_q;
    wire dbLoad = demandDone && (engKind_q == ffa_pkg::ENG_DATA);
    wire [TAG_W-1:0] pfLoadTag = pfMoveHeld ? pfHeldLine_q : engLine_q;
    wire [LINE_W-1:0] pfLoadLine = pfMoveHeld ? pfHeldData_q : flashLineData;
    wire instrLoaded = pfLoad || btLoad;

    ffa_line_buf #(.LINE_W(LINE_W), .WORD_W(WORD_W), .TAG_W(TAG_W)) u_pf_buf (
        .core_clk(core_clk),
        .rst(rst),
        .invalidate(invalidate),
        .load(pfLoad),
        .loadTag(pfLoadTag),
        .loadLine(pfLoadLine),
        .lookupTag(reqLine),
        .wordSel(wsel),
        .hit(pfHit),
        .word(pfWord)
    );

    ffa_line_buf #(.LINE_W(LINE_W), .WORD_W(WORD_W), .TAG_W(TAG_W)) u_bt_buf (
        .core_clk(core_clk),
        .rst(rst),
        .invalidate(invalidate),
        .load(btLoad),
        .loadTag(engLine_q),
        .loadLine(flashLineData),
        .lookupTag(reqLine),
        .wordSel(wsel),
        .hit(btHit),
        .word(btWord)
    );

    ffa_line_buf #(.LINE_W(LINE_W), .WORD_W(WORD_W), .TAG_W(TAG_W)) u_data_buf (
        .core_clk(core_clk),
        .rst(rst),
        .invalidate(invalidate),
        .load(dbLoad),
        .loadTag(engLine_q),
        .loadLine(flashLineData),
        .lookupTag(reqLine),
        .wordSel(wsel),
        .hit(dHit),
        .word(dWord)
    );

    // ****************************************************************
    // prefetch holding latch and next line
    // ****************************************************************
    wire heldCapture = prefDone && (state_q != ffa_pkg::ST_PFWAIT) && !invalidate;
    wire heldDrop = invalidate || pfMoveHeld || (demandStart && isInstr);

    // the finished prefetch line is held in pfHeldData_q until the core asks for it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pfHeldValid_q <= 1'b0;
        end else if (heldCapture) begin
            pfHeldValid_q <= 1'b1;
        end else if (heldDrop) begin
            pfHeldValid_q <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (heldCapture) begin
            pfHeldLine_q <= engLine_q;
            pfHeldData_q <= flashLineData;
        end
    end

    // next prefetch line, set wins over the clear at launch
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pfWanted_q <= 1'b0;
            pfNext_q <= '0;
        end else if (instrLoaded && pfEnabled && !invalidate) begin
            pfWanted_q <= 1'b1;
            pfNext_q <= (btLoad ? engLine_q : pfLoadTag) + TAG_W'(1);
        end else if (pfAbortByDemand && !invalidate) begin
            pfWanted_q <= 1'b1;
        end else if (pfLaunch || invalidate) begin
            pfWanted_q <= 1'b0;
        end
    end

    // ****************************************************************
    // control state machine and wait logic
    // ****************************************************************
    wire mimicStart = take && mimicGo && !bypass;
    logic readyNow;
    logic [WORD_W-1:0] respWord;

    ffa_fetch_timer #(.TIM_W(ffa_pkg::TIM_W)) u_mimic_timer (
        .core_clk(core_clk),
        .rst(rst),
        .start(mimicStart),
        .abort(1'b0),
        .len(cfgTim_q),
        .busy(),
        .done(mimicDone)
    );

    // next state, answer strobe and answer word
    always_comb begin
        state_d = state_q;
        readyNow = 1'b0;
        respWord = bufWord;
        case (state_q)
            ffa_pkg::ST_IDLE: begin
                if (take) begin
                    if (serveFast || (mimicGo && bypass)) begin
                        readyNow = 1'b1;
                    end else if (mimicGo) begin
                        state_d = ffa_pkg::ST_MIMIC;
                    end else if (heldMatch) begin
                        readyNow = 1'b1;
                        respWord = pickWord(pfHeldData_q, wsel);
                    end else if (flightMatch) begin
                        state_d = ffa_pkg::ST_PFWAIT;
                    end else begin
                        state_d = ffa_pkg::ST_FETCH;
                    end
                end
            end
            ffa_pkg::ST_MIMIC: begin
                respWord = mimicWord_q;
                if (mimicDone) begin
                    readyNow = 1'b1;
                    state_d = ffa_pkg::ST_IDLE;
                end
            end
            ffa_pkg::ST_PFWAIT: begin
                respWord = pickWord(flashLineData, wsel);
                if (prefDone) begin
                    readyNow = 1'b1;
                    state_d = ffa_pkg::ST_IDLE;
                end else if (!engBusy || engAbort) begin
                    state_d = ffa_pkg::ST_IDLE; // lost prefetch, request is taken anew
                end
            end
            ffa_pkg::ST_FETCH: begin
                respWord = pickWord(flashLineData, wsel);
                if (engDone) begin
                    readyNow = 1'b1;
                    state_d = ffa_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = ffa_pkg::ST_IDLE;
            end
        endcase
    end

    wire gateHold = coreReq.valid && flashProgBusy;
    wire waitGate_d = (state_d == ffa_pkg::ST_IDLE) && !gateHold && !(take && !readyNow);

    // state, answer and core wait gate registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= ffa_pkg::ST_IDLE;
            coreReady_q <= 1'b0;
            coreRdData_q <= '0;
            coreWaitGate_q <= 1'b1;
            mimicWord_q <= '0;
        end else begin
            state_q <= state_d;
            coreReady_q <= readyNow;
            coreWaitGate_q <= waitGate_d;
            if (readyNow) begin
                coreRdData_q <= respWord;
            end
            if (mimicStart) begin
                mimicWord_q <= bufWord;
            end
        end
    end

    assign flashReq = flashReq_q;
    assign coreWaitGate = coreWaitGate_q;
    assign coreReady = coreReady_q;
    assign coreRdData = coreRdData_q;
    assign modeOut = cfgMode_q;
    assign timingOut = cfgTim_q;

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_mimic7;
        (!coreReady_q) [*7] ##1 coreReady_q;
    endsequence

    property p_fast_hit;
        @(posedge core_clk) disable iff (rst)
        take && serveFast |=> coreReady_q && (coreRdData_q == $past(bufWord));
    endproperty
    a_fast_hit: assert property (p_fast_hit) else $error("buffer hit not served");

    property p_mimic;
        @(posedge core_clk) disable iff (rst)
        mimicStart && (cfgTim_q == 3'h7) |-> ##1 s_mimic7;
    endproperty
    a_mimic: assert property (p_mimic) else $error("mimic timing wrong");

    property p_bypass;
        @(posedge core_clk) disable iff (rst)
        take && mimicGo && bypass |=> coreReady_q;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass added delay");

    property p_miss_stall;
        @(posedge core_clk) disable iff (rst)
        goFetch |=> flashReq_q.rdEn && !coreWaitGate_q && (flashReq_q.line == $past(reqLine));
    endproperty
    a_miss_stall: assert property (p_miss_stall) else $error("miss did not stall");

    property p_prog_wait;
        @(posedge core_clk) disable iff (rst)
        gateHold |=> !coreWaitGate_q;
    endproperty
    a_prog_wait: assert property (p_prog_wait) else $error("core not held");

    property p_invalidate;
        @(posedge core_clk) disable iff (rst)
        invalidate |=> !pfHit && !btHit && !dHit && !pfHeldValid_q;
    endproperty
    a_invalidate: assert property (p_invalidate) else $error("buffer survived");

    property p_no_pref_off;
        @(posedge core_clk) disable iff (rst)
        $rose(flashReq_q.rdEn) && (engKind_q == ffa_pkg::ENG_PREF) |-> $past(pfEnabled);
    endproperty
    a_no_pref_off: assert property (p_no_pref_off) else $error("prefetch when off");

    property p_data_abort;
        @(posedge core_clk) disable iff (rst)
        pfAbortByDemand && !isInstr && !invalidate |=> (engKind_q == ffa_pkg::ENG_DATA)
            && pfWanted_q;
    endproperty
    a_data_abort: assert property (p_data_abort) else $error("prefetch not aborted");

    property p_discard;
        @(posedge core_clk) disable iff (rst)
        demandStart && isInstr && !heldCapture |=> !pfHeldValid_q;
    endproperty
    a_discard: assert property (p_discard) else $error("stale prefetch kept");

    property p_reset_cfg;
        @(posedge core_clk)
        $past(rst) && !rst |-> (cfgMode_q == ffa_pkg::MODE_OFF)
            && (cfgTim_q == ffa_pkg::TIM_RESET);
    endproperty
    a_reset_cfg: assert property (p_reset_cfg) else $error("bad reset config");
endmodule

// ---- sim/ffa_flash_model.sv ----
// flash bank model: serves a line pattern while a read runs
`timescale 1ns/1ps
module ffa_flash_model (
    input wire logic core_clk,
    input ffa_pkg::ffa_flash_req_t flashReq,
    output logic [127:0] flashLineData
);
    logic [127:0] lastQ = 128'h0;
    wire [127:0] pat = {flashReq.line, 15'h0, 2'h3, flashReq.line, 15'h0, 2'h2,
                        flashReq.line, 15'h0, 2'h1, flashReq.line, 15'h0, 2'h0};
    // outside a read the lines show the inverse of the last value
    assign flashLineData = flashReq.rdEn ? pat : ~lastQ;
    always_ff @(posedge core_clk) begin
        lastQ <= flashLineData;
    end
endmodule

// ---- sim/test_flash_fetch_accelerator.sv ----
// bench for the flash fetch accelerator
`timescale 1ns/1ps
module test_flash_fetch_accelerator;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    ffa_pkg::ffa_core_req_t coreReq = '0;
    ffa_pkg::ffa_cfg_t cfgIn = '0;
    logic flashProgBusy = 1'b0;
    logic flashProgStart = 1'b0;
    logic [127:0] flashLineData;
    ffa_pkg::ffa_flash_req_t flashReq;
    logic coreWaitGate, coreReady;
    logic [31:0] coreRdData;
    logic [1:0] modeOut;
    logic [2:0] timingOut;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    always #2 core_clk = ~core_clk;
    ffa_flash_accel i_dut (.core_clk(core_clk), .rst(rst), .coreReq(coreReq), .cfgIn(cfgIn),
        .flashProgBusy(flashProgBusy), .flashProgStart(flashProgStart),
        .flashLineData(flashLineData), .flashReq(flashReq), .coreWaitGate(coreWaitGate),
        .coreReady(coreReady), .coreRdData(coreRdData), .modeOut(modeOut),
        .timingOut(timingOut));
    ffa_flash_model i_flash (.core_clk(core_clk), .flashReq(flashReq),
        .flashLineData(flashLineData));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // cut a hang short
    always @(posedge core_clk) begin
        cycles++;
        if (cycles > 4000) begin
            errors++;
            final_report();
        end
    end
    task automatic cfg(input logic [1:0] m, input logic [2:0] t);
        cfgIn = {1'b1, m, t};
        @(negedge core_clk) cfgIn.wr = 1'b0;
        @(negedge core_clk);
    endtask
    task automatic rq(input logic [31:0] a, input logic k, input logic s);
        coreReq = {1'b1, s, {1'b0, k}, a};
    endtask
    // wait for the answer, check latency from take and the word
    task automatic wt(input int lat, input logic [31:0] a);
        int n;
        n = 0;
        while (coreReady !== 1'b1 && n < 40) begin
            @(negedge core_clk) n++;
        end
        coreReq.valid = 1'b0;
        chk(32'(n), 32'(lat));
        chk(coreRdData, {a[18:4], 15'h0, a[3:2]});
        @(negedge core_clk);
    endtask
    task automatic rw(input logic [31:0] a, input logic k, input logic s, input int lat);
        rq(a, k, s);
        wt(lat, a);
    endtask
    task automatic t_reset_cfg;
        chk({modeOut, timingOut, coreWaitGate, flashReq.rdEn}, {2'h0, 3'h7, 1'b1, 1'b0});
        cfg(2'h3, 3'h0);
        chk({modeOut, timingOut}, {2'h0, 3'h7});
        cfg(2'h2, 3'h3);
        chk({modeOut, timingOut}, {2'h2, 3'h3});
    endtask
    task automatic t_full;
        rw(32'h120, 1'b0, 1'b0, 4);
        rw(32'h12c, 1'b0, 1'b1, 1);
        repeat (10) @(negedge core_clk);
        rw(32'h130, 1'b0, 1'b1, 1);
        rw(32'h2044, 1'b1, 1'b1, 4);
        rw(32'h2048, 1'b1, 1'b1, 1);
    endtask
    task automatic t_prog;
        repeat (10) @(negedge core_clk);
        flashProgStart = 1'b1;
        flashProgBusy = 1'b1;
        @(negedge core_clk) flashProgStart = 1'b0;
        rq(32'h124, 1'b0, 1'b1);
        repeat (3) @(negedge core_clk);
        chk(32'(coreWaitGate), 32'h0);
        flashProgBusy = 1'b0;
        wt(4, 32'h124);
    endtask
    task automatic t_modes;
        cfg(2'h0, 3'h3);
        chk(32'(modeOut), 32'h0);
        rw(32'h124, 1'b0, 1'b1, 4);
        rw(32'h128, 1'b0, 1'b1, 4);
        cfg(2'h0, 3'h1);
        rw(32'h128, 1'b0, 1'b1, 1);
    endtask
    initial begin
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        t_reset_cfg();
        t_full();
        t_prog();
        t_modes();
        final_report();
    end
endmodule
